/* design/ssp_serial_port_regs.vh */
// Register map, field positions and timing counts of the synchronous serial port.
// Assumes a byte-addressed APB with 32-bit data; each register sits in the low bits of a word.
`ifndef SSP_SERIAL_PORT_REGS_VH
`define SSP_SERIAL_PORT_REGS_VH

// Byte addresses of the registers.
`define SSP_ADDR_CTRL   8'h14
`define SSP_ADDR_STAT   8'h94
`define SSP_ADDR_DATA   8'h18
`define SSP_ADDR_SADR   8'h1c

// Status register fields.
`define SSP_ST_SMP      7
`define SSP_ST_CKE      6
`define SSP_ST_DA       5
`define SSP_ST_STOP     4
`define SSP_ST_START    3
`define SSP_ST_RW       2
`define SSP_ST_UA       1
`define SSP_ST_BF       0

// Control register fields.
`define SSP_CT_WRITE_COLLISION     7
`define SSP_CT_OVF      6
`define SSP_CT_EN       5
`define SSP_CT_CKP      4

// Mode select codes.
`define SSP_MODE_DIV4   4'h0
`define SSP_MODE_DIV16  4'h1
`define SSP_MODE_DIV64  4'h2
`define SSP_MODE_TMR2   4'h3
`define SSP_MODE_SS_ON  4'h4
`define SSP_MODE_SS_OFF 4'h5
`define SSP_MODE_I2C7   4'h6
`define SSP_MODE_I2C10  4'h7
`define SSP_MODE_FWMST  4'hb
`define SSP_MODE_I2C7S  4'he
`define SSP_MODE_I2C10S 4'hf

// Half periods of the master serial clock, in device clock cycles.
`define SSP_HALF_DIV4   6'h02
`define SSP_HALF_DIV16  6'h08
`define SSP_HALF_DIV64  6'h20

// Transfer shape: clock edges and bits per word.
`define SSP_EDGES       5'h10
`define SSP_BITS        4'h8
`define SSP_LAST_BIT    4'h7
`define SSP_RESET8      8'h00

`endif

/* design/ssp_serial_port.v */
// Synchronous serial port: SPI master or slave, or I2C slave, with an APB register slave.
// Assumes pin inputs are asynchronous and tmr2Tick is a one-cycle pulse on the same clock.
//
// Chosen here: register access over APB.
`include "ssp_serial_port_regs.vh"

module ssp_serial_port
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        tmr2Tick,
  input  wire        sckIn,
  output wire        sckOut,
  output wire        sckOe,
  input  wire        sdiIn,
  output wire        sdiOut,
  output wire        sdiOe,
  output wire        sdoOut,
  output wire        sdoOe,
  input  wire        slaveSelectN
);

  // One-hot states of the I2C slave.
  localparam [4:0] I2C_IDLE = 5'b00001;
  localparam [4:0] I2C_RX   = 5'b00010;
  localparam [4:0] I2C_ACK  = 5'b00100;
  localparam [4:0] I2C_TX   = 5'b01000;
  localparam [4:0] I2C_TACK = 5'b10000;

  // Software visible state.
  reg       writeCollision;
  reg       receiveOverflow;
  reg       portEnable;
  reg       clockIdlePolarity;
  reg [3:0] portModeSelect;
  reg       samplePhase;
  reg       clockEdge;
  reg       dataNotAddress;
  reg       stopSeen;
  reg       startSeen;
  reg       readNotWrite;
  reg       addressUpdateNeeded;
  reg       bufferFull;
  reg [7:0] dataBuffer;
  reg [7:0] slaveAddressRegister;

  // Shifting engine.
  reg [7:0] txShift;
  reg [7:0] shiftRegister;
  reg [3:0] rxCount;
  reg       txPrimed;
  reg       masterBusy;
  reg [4:0] edgeCount;
  reg [5:0] divCount;
  reg       sckReg;

  // Pin synchronisers and edge history.
  reg       sckMeta;
  reg       sckSync;
  reg       sckPrev;
  reg       sdiMeta;
  reg       sdiSync;
  reg       sdiPrev;
  reg       ssMeta;
  reg       ssSync;

  // I2C slave state.
  reg [4:0] i2cState;
  reg [3:0] i2cCount;
  reg       isAddress;
  reg       sdaDrive;
  reg       tackOk;

  // Mode decode.
  wire spiMaster = portEnable & (portModeSelect[3:2] == 2'b00);
  wire spiSlave  = portEnable & ((portModeSelect == `SSP_MODE_SS_ON) |
                                 (portModeSelect == `SSP_MODE_SS_OFF));
  wire ssControl = (portModeSelect == `SSP_MODE_SS_ON);
  wire i2cSlave  = portEnable & ((portModeSelect == `SSP_MODE_I2C7) |
                                 (portModeSelect == `SSP_MODE_I2C10) |
                                 (portModeSelect == `SSP_MODE_I2C7S) |
                                 (portModeSelect == `SSP_MODE_I2C10S));
  wire i2cOn     = i2cSlave | (portEnable & (portModeSelect == `SSP_MODE_FWMST));
  wire tenBit    = portModeSelect[0];

  // Clock phase: the clock-edge bit alone says whether the first edge transmits.
  wire txOnRising = clockEdge ^ clockIdlePolarity;
  wire cpha       = clockEdge;

  // Master clock rate from the mode field.
  reg  [5:0] halfLen;
  always @*
  begin
    case (portModeSelect[1:0])
      2'b00:   halfLen = `SSP_HALF_DIV4;
      2'b01:   halfLen = `SSP_HALF_DIV16;
      default: halfLen = `SSP_HALF_DIV64;
    endcase
  end
  wire useTmr2  = (portModeSelect == `SSP_MODE_TMR2);
  wire tick     = spiMaster & masterBusy &
                  (useTmr2 ? tmr2Tick : (divCount == halfLen - 6'h01));
  wire edgeLive = (edgeCount < `SSP_EDGES);
  wire isTxEdge = edgeLive & (edgeCount[0] ^ cpha);

  // Master transmit and sample points; sample-phase moves sampling to the end of the bit.
  wire mTx     = tick & isTxEdge;
  wire mSample = tick & (samplePhase ?
                   ((isTxEdge & ~(cpha & (edgeCount == 5'h00))) |
                    (cpha & (edgeCount == `SSP_EDGES))) :
                   (edgeLive & ~isTxEdge));
  wire mDone   = tick & (edgeCount == `SSP_EDGES);

  // Slave edges come from the synchronised pin clock, gated by the select.
  wire sckRise  = sckSync & ~sckPrev;
  wire sckFall  = ~sckSync & sckPrev;
  wire ssActive = ~ssControl | ~ssSync;
  wire sTx      = spiSlave & ssActive & (txOnRising ? sckRise : sckFall);
  wire sRx      = spiSlave & ssActive & (txOnRising ? sckFall : sckRise);
  wire sDone    = sRx & (rxCount == `SSP_LAST_BIT);
  wire doTx     = mTx | sTx;
  wire doRx     = mSample | sRx;
  wire [7:0] rxWord = {shiftRegister[6:0], sdiSync};

  // I2C bus conditions, seen while the clock stays high.
  wire sclHigh  = sckSync & sckPrev;
  wire startDet = i2cOn & sclHigh & ~sdiSync & sdiPrev;
  wire stopDet  = i2cOn & sclHigh & sdiSync & ~sdiPrev;
  wire addrHit  = (rxWord[7:1] == slaveAddressRegister[7:1]);

  // Busy as seen by a buffer write.
  wire spiBusy  = masterBusy | (spiSlave & (rxCount != 4'h0));
  wire i2cBusy  = i2cSlave & (i2cState == I2C_TX);

  // APB decode: zero wait states, error on an unmapped address.
  wire access  = psel & penable;
  wire hitCtrl = (paddr == `SSP_ADDR_CTRL);
  wire hitStat = (paddr == `SSP_ADDR_STAT);
  wire hitData = (paddr == `SSP_ADDR_DATA);
  wire hitSadr = (paddr == `SSP_ADDR_SADR);
  wire mapped  = hitCtrl | hitStat | hitData | hitSadr;
  wire wrData  = access & pwrite & hitData;
  wire rdData  = access & ~pwrite & hitData;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Read data is captured in the setup phase so the bus sees a flip-flop.
  always @(posedge clock)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel & ~penable)
    begin
      prdata <= 32'h00000000;
      if (hitCtrl)
        prdata[7:0] <= {writeCollision, receiveOverflow, portEnable,
                        clockIdlePolarity, portModeSelect};
      else if (hitStat)
        prdata[7:0] <= {samplePhase, clockEdge, dataNotAddress, stopSeen,
                        startSeen, readNotWrite, addressUpdateNeeded, bufferFull};
      else if (hitData)
        prdata[7:0] <= dataBuffer;
      else if (hitSadr)
        prdata[7:0] <= slaveAddressRegister;
    end
  end

  // Two flip-flops on every pin input before any logic looks at it.
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      sckMeta <= 1'b0;
      sckSync <= 1'b0;
      sckPrev <= 1'b0;
      sdiMeta <= 1'b1;
      sdiSync <= 1'b1;
      sdiPrev <= 1'b1;
      ssMeta  <= 1'b1;
      ssSync  <= 1'b1;
    end
    else
    begin
      sckMeta <= sckIn;
      sckSync <= sckMeta;
      sckPrev <= sckSync;
      sdiMeta <= sdiIn;
      sdiSync <= sdiMeta;
      sdiPrev <= sdiSync;
      ssMeta  <= slaveSelectN;
      ssSync  <= ssMeta;
    end
  end

  // Registers, SPI engine and I2C slave share one process so each flag has one driver.
  // Later assignments win, which is how a hardware set beats a software clear.
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      writeCollision       <= 1'b0;
      receiveOverflow      <= 1'b0;
      portEnable           <= 1'b0;
      clockIdlePolarity    <= 1'b0;
      portModeSelect       <= `SSP_MODE_DIV4;
      samplePhase          <= 1'b0;
      clockEdge            <= 1'b0;
      dataNotAddress       <= 1'b0;
      stopSeen             <= 1'b0;
      startSeen            <= 1'b0;
      readNotWrite         <= 1'b0;
      addressUpdateNeeded  <= 1'b0;
      bufferFull           <= 1'b0;
      dataBuffer           <= `SSP_RESET8;
      slaveAddressRegister <= `SSP_RESET8;
      txShift              <= `SSP_RESET8;
      shiftRegister        <= `SSP_RESET8;
      rxCount              <= 4'h0;
      txPrimed             <= 1'b0;
      masterBusy           <= 1'b0;
      edgeCount            <= 5'h00;
      divCount             <= 6'h00;
      sckReg               <= 1'b0;
      i2cState             <= I2C_IDLE;
      i2cCount             <= 4'h0;
      isAddress            <= 1'b0;
      sdaDrive             <= 1'b0;
      tackOk               <= 1'b0;
    end
    else
    begin
      // Software writes to control, status and address registers.
      if (access & pwrite & hitCtrl)
      begin
        writeCollision    <= pwdata[`SSP_CT_WRITE_COLLISION];
        receiveOverflow   <= pwdata[`SSP_CT_OVF];
        portEnable        <= pwdata[`SSP_CT_EN];
        clockIdlePolarity <= pwdata[`SSP_CT_CKP];
        portModeSelect    <= pwdata[3:0];
      end
      if (access & pwrite & hitStat)
      begin
        samplePhase <= pwdata[`SSP_ST_SMP];
        clockEdge   <= pwdata[`SSP_ST_CKE];
      end
      if (access & pwrite & hitSadr)
      begin
        slaveAddressRegister <= pwdata[7:0];
        addressUpdateNeeded  <= 1'b0;
      end
      // Reading the buffer empties it.
      if (rdData)
        bufferFull <= 1'b0;

      // Buffer write: a collision is flagged and the write dropped while busy.
      if (wrData)
      begin
        if (spiBusy | i2cBusy)
          writeCollision <= 1'b1;
        else
        begin
          dataBuffer <= pwdata[7:0];
          if (spiMaster | spiSlave)
          begin
            txShift  <= pwdata[7:0];
            txPrimed <= 1'b0;
            rxCount  <= 4'h0;
          end
          if (spiMaster)
          begin
            masterBusy <= 1'b1;
            edgeCount  <= 5'h00;
            divCount   <= 6'h00;
          end
        end
      end

      // Master clock divider and clock pin level.
      if (masterBusy & ~useTmr2)
        divCount <= tick ? 6'h00 : divCount + 6'h01;
      if (~masterBusy)
        sckReg <= clockIdlePolarity;
      if (tick)
      begin
        edgeCount <= edgeCount + 5'h01;
        if (edgeLive)
          sckReg <= ~sckReg;
      end

      // Transmit edges move the next bit out; the first in phase 1 only primes.
      if (doTx)
      begin
        if (cpha & ~txPrimed)
          txPrimed <= 1'b1;
        else
          txShift <= {txShift[6:0], 1'b0};
      end
      if (doRx)
      begin
        shiftRegister <= rxWord;
        rxCount       <= rxCount + 4'h1;
      end

      // End of a master word: the buffer always takes it.
      if (mDone)
      begin
        masterBusy <= 1'b0;
        dataBuffer <= shiftRegister;
        bufferFull <= 1'b1;
        rxCount    <= 4'h0;
      end
      // End of a slave word: a full buffer drops the new byte.
      if (sDone)
      begin
        rxCount  <= 4'h0;
        txPrimed <= 1'b0;
        if (bufferFull & ~rdData)
          receiveOverflow <= 1'b1;
        else
        begin
          dataBuffer <= rxWord;
          bufferFull <= 1'b1;
        end
      end
      // Select released: the slave word restarts from its first bit.
      if (spiSlave & ssControl & ssSync)
      begin
        rxCount  <= 4'h0;
        txPrimed <= 1'b0;
      end

      // I2C slave engine; bus conditions abort any byte in flight.
      if (i2cOn)
      begin
        case (i2cState)
          I2C_IDLE:
          begin
            sdaDrive <= 1'b0;
          end
          I2C_RX:
          begin
            if (sckRise)
            begin
              shiftRegister <= rxWord;
              i2cCount      <= i2cCount + 4'h1;
              if (i2cCount == `SSP_LAST_BIT)
              begin
                i2cCount <= 4'h0;
                i2cState <= I2C_IDLE;
                if (~isAddress | addrHit)
                begin
                  if (bufferFull & ~rdData)
                    receiveOverflow <= 1'b1;
                  else
                  begin
                    dataBuffer     <= rxWord;
                    bufferFull     <= 1'b1;
                    dataNotAddress <= ~isAddress;
                    i2cState       <= I2C_ACK;
                    if (isAddress)
                    begin
                      readNotWrite        <= rxWord[0];
                      addressUpdateNeeded <= tenBit;
                    end
                  end
                end
              end
            end
          end
          I2C_ACK:
          begin
            if (sckFall)
            begin
              if (~sdaDrive)
                sdaDrive <= 1'b1;
              else if (readNotWrite)
              begin
                i2cState   <= I2C_TX;
                txShift    <= dataBuffer;
                sdaDrive   <= ~dataBuffer[7];
                bufferFull <= 1'b1;
                i2cCount   <= 4'h0;
              end
              else
              begin
                sdaDrive  <= 1'b0;
                isAddress <= 1'b0;
                i2cState  <= I2C_RX;
              end
            end
          end
          I2C_TX:
          begin
            if (sckRise)
              i2cCount <= i2cCount + 4'h1;
            if (sckFall)
            begin
              if (i2cCount == `SSP_BITS)
              begin
                sdaDrive       <= 1'b0;
                bufferFull     <= 1'b0;
                dataNotAddress <= 1'b1;
                tackOk         <= 1'b0;
                i2cState       <= I2C_TACK;
              end
              else
              begin
                txShift  <= {txShift[6:0], 1'b0};
                sdaDrive <= ~txShift[6];
              end
            end
          end
          I2C_TACK:
          begin
            // A high level at the ninth clock is the master's not-acknowledge.
            if (sckRise)
            begin
              tackOk <= ~sdiSync;
              if (sdiSync)
                i2cState <= I2C_IDLE;
            end
            if (sckFall & tackOk)
            begin
              i2cState   <= I2C_TX;
              txShift    <= dataBuffer;
              sdaDrive   <= ~dataBuffer[7];
              bufferFull <= 1'b1;
              i2cCount   <= 4'h0;
            end
          end
          default:
          begin
            i2cState <= I2C_IDLE;
          end
        endcase
        if (startDet)
        begin
          startSeen    <= 1'b1;
          stopSeen     <= 1'b0;
          readNotWrite <= 1'b0;
          sdaDrive     <= 1'b0;
          isAddress    <= 1'b1;
          i2cCount     <= 4'h0;
          i2cState     <= i2cSlave ? I2C_RX : I2C_IDLE;
        end
        if (stopDet)
        begin
          stopSeen     <= 1'b1;
          startSeen    <= 1'b0;
          readNotWrite <= 1'b0;
          sdaDrive     <= 1'b0;
          i2cState     <= I2C_IDLE;
        end
      end

      // A disabled port forgets any transfer and the bus condition flags.
      if (~portEnable)
      begin
        startSeen  <= 1'b0;
        stopSeen   <= 1'b0;
        masterBusy <= 1'b0;
        rxCount    <= 4'h0;
        txPrimed   <= 1'b0;
        sdaDrive   <= 1'b0;
        i2cState   <= I2C_IDLE;
      end
    end
  end

  // Pin drivers; a cleared enable leaves every pin to general-purpose I/O.
  // SDA is open drain, so only a low level is ever driven onto it.
  assign sckOut = sckReg;
  assign sckOe  = spiMaster;
  assign sdoOut = txShift[7];
  assign sdoOe  = spiMaster | (spiSlave & ssActive);
  assign sdiOut = 1'b0;
  assign sdiOe  = i2cSlave & sdaDrive;

endmodule

/* bench/ssp_serial_port_asserts.sv */
// Checker for the serial port; it shadows control and status bits from APB writes.
// Assumes it is bound to ssp_serial_port and sees only that module's ports.
`include "ssp_serial_port_regs.vh"
module ssp_serial_port_asserts
(
  input logic        clock,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic        sckOut,
  input logic        sckOe,
  input logic        sdiOe,
  input logic        sdoOut,
  input logic        sdoOe,
  input logic        slaveSelectN
);
  logic [5:0] ctl;
  logic       cke;
  logic       txMsb;
  logic [7:0] gap;
  // Bus decodes; the shadow lags nothing because writes land at the access edge.
  wire acc = psel && penable;
  wire wrCtl = acc && pwrite && paddr == `SSP_ADDR_CTRL;
  wire wrDat = acc && pwrite && paddr == `SSP_ADDR_DATA;
  wire master = ctl[5] && ctl[3:2] == 2'b00;
  wire mapped = paddr == `SSP_ADDR_CTRL || paddr == `SSP_ADDR_STAT
                || paddr == `SSP_ADDR_DATA || paddr == `SSP_ADDR_SADR;

  // Gap counts cycles since a buffer write, so writes that collide are told apart.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl   <= 6'h00;
      cke   <= 1'b0;
      txMsb <= 1'b0;
      gap   <= 8'hff;
    end
    else
    begin
      if (wrCtl) ctl <= pwdata[5:0];
      if (acc && pwrite && paddr == `SSP_ADDR_STAT) cke <= pwdata[6];
      if (wrDat) txMsb <= pwdata[7];
      gap <= wrDat ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_err;
    acc |-> pslverr == !mapped;
  endproperty
  a_err: assert property (p_err)
    else $error("slave error does not follow the address");
  property p_master_oe;
    master [*3] |-> sckOe;
  endproperty
  a_master_oe: assert property (p_master_oe)
    else $error("master does not drive the clock pin");
  property p_slave_oe;
    (ctl[5] && ctl[3:2] != 2'b00) [*3] |-> !sckOe;
  endproperty
  a_slave_oe: assert property (p_slave_oe)
    else $error("clock pin driven outside master mode");
  property p_off;
    !ctl[5] [*3] |-> !sckOe && !sdoOe && !sdiOe;
  endproperty
  a_off: assert property (p_off)
    else $error("pins driven while disabled");
  property p_idle;
    wrCtl && pwdata[5] && pwdata[3:2] == 2'b00 && !ctl[5] |-> ##2 sckOut == ctl[4];
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock idle level wrong");
  property p_ovf;
    acc && !pwrite && paddr == `SSP_ADDR_CTRL && master |-> !prdata[6];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow seen in master mode");
  property p_select;
    (ctl[5] && ctl[3:0] == 4'h4 && slaveSelectN) [*5] |-> !sdoOe;
  endproperty
  a_select: assert property (p_select)
    else $error("data out driven while deselected");
  sequence s_start;
    wrDat && master && !cke && gap > 8'h10;
  endsequence
  property p_msb;
    s_start |-> ##[1:3] sdoOut == txMsb;
  endproperty
  a_msb: assert property (p_msb)
    else $error("first bit out is not the top bit");
endmodule

bind ssp_serial_port ssp_serial_port_asserts ssp_serial_port_asserts_inst
(
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .sckOut(sckOut), .sckOe(sckOe), .sdiOe(sdiOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
  .slaveSelectN(slaveSelectN)
);

/* bench/ssp_spi_partner.sv */
// Far side of the port: an SPI slave while the port is master, else a 64 ns SPI master.
// Assumes idle-low clock with data changing on the falling edge.
module ssp_spi_partner
(
  input  logic       sckOut,
  input  logic       sckOe,
  input  logic       sdoOut,
  input  logic       sdoOe,
  input  logic       sdiOe,
  output logic       sckIn,
  output logic       sdiIn,
  output logic       slaveSelectN,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sckDrv = 1'b0;
  logic       sdiDrv = 1'b0;
  logic [7:0] txSh = 8'h00;
  int         cnt = 0;
  initial slaveSelectN = 1'b1;
  initial rxByte = 8'h00;

  // Pin levels; a released data line shows the inverse of its last bit.
  assign sckIn = sckOe ? sckOut : sckDrv;
  assign sdiIn = sdiOe ? 1'b0 : sdiDrv;

  // Slave side: take the port's bit on the rise, present the next on the fall.
  always @(posedge sckOut)
    if (sckOe)
      rxByte <= {rxByte[6:0], sdoOe ? sdoOut : ~rxByte[0]};
  always @(negedge sckOut)
    if (sckOe)
    begin
      txSh = {txSh[6:0], 1'b0};
      cnt = cnt + 1;
      sdiDrv = (cnt == 8) ? ~sdiDrv : txSh[7];
    end

  task automatic arm(input logic [7:0] b);
    txSh = b;
    cnt = 0;
    sdiDrv = b[7];
  endtask

  // Master side: select low for the whole word; clock stands still outside it.
  task automatic xfer(input logic [7:0] b);
    #7;
    slaveSelectN = 1'b0;
    sdiDrv = b[7];
    #64;
    for (int i = 6; i >= -1; i--)
    begin
      sckDrv = 1'b1;
      rxByte = {rxByte[6:0], sdoOe ? sdoOut : ~rxByte[0]};
      #32;
      sckDrv = 1'b0;
      sdiDrv = (i >= 0) ? b[i] : ~sdiDrv;
      #32;
    end
    slaveSelectN = 1'b1;
  endtask

  // I2C side: a start, eight bits and an acknowledge clock on 64 ns clocks.
  // The data line is released for the ninth clock so that the port's acknowledge shows.
  task automatic i2cAddr(input logic [7:0] b);
    sdiDrv = 1'b1;
    sckDrv = 1'b1;
    #64;
    sdiDrv = 1'b0;
    #32;
    for (int i = 7; i >= -1; i--)
    begin
      sckDrv = 1'b0;
      #16;
      sdiDrv = (i >= 0) ? b[i] : 1'b1;
      #16;
      sckDrv = 1'b1;
      #32;
    end
    sckDrv = 1'b0;
    #32;
  endtask

  // Stop: the data line rises while the clock stands high.
  task automatic i2cStop;
    sdiDrv = 1'b0;
    #32;
    sckDrv = 1'b1;
    #32;
    sdiDrv = 1'b1;
    #32;
  endtask
endmodule

/* bench/ssp_serial_port_bench.sv */
// Self-checking bench for the serial port; one task per scenario over APB.
// Assumes the design, header, partner model and checker are compiled first.
`include "ssp_serial_port_regs.vh"
module ssp_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        tmr2Tick = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sckIn, sckOut, sckOe, sdiIn, sdiOut, sdiOe;
  logic        sdoOut, sdoOe, slaveSelectN;
  logic [7:0]  rxByte;
  int          failures = 0;
  int          tests_run = 0;

  ssp_serial_port ssp_serial_port_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr2Tick(tmr2Tick), .sckIn(sckIn), .sckOut(sckOut),
    .sckOe(sckOe), .sdiIn(sdiIn), .sdiOut(sdiOut), .sdiOe(sdiOe), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .slaveSelectN(slaveSelectN));
  ssp_spi_partner ssp_spi_partner_inst (.sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .sdiOe(sdiOe), .sckIn(sckIn), .sdiIn(sdiIn),
    .slaveSelectN(slaveSelectN), .rxByte(rxByte));

  // 200 MHz clock.
  initial forever #2.5 clock = ~clock;

  // Timer pulse on every other cycle, so mode 3 runs the fastest serial clock.
  always @(posedge clock) tmr2Tick <= ~tmr2Tick;

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic fail(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp)
      fail(m);
  endtask

  // One transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      if (++n > 20)
      begin
        fail("bus timeout");
        finish_test();
      end
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic waitBf;
    int n = 0;
    do
    begin
      if (++n > 100)
      begin
        fail("buffer never filled");
        finish_test();
      end
      apb(`SSP_ADDR_STAT, 1'b0, 8'h00);
    end
    while (rd[0] !== 1'b1);
  endtask

  task automatic t_regs;
    apb(`SSP_ADDR_CTRL, 1'b0, 8'h00);
    chk(rd[7:0], 8'h00, "control reset");
    apb(`SSP_ADDR_STAT, 1'b1, 8'hff);
    apb(`SSP_ADDR_STAT, 1'b0, 8'h00);
    chk(rd[7:0], 8'hc0, "status access");
    apb(`SSP_ADDR_STAT, 1'b1, 8'h00);
    apb(8'h40, 1'b0, 8'h00);
    chk({7'h0, err}, 8'h01, "unmapped address");
  endtask

  task automatic t_modes;
    logic [3:0] m [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb, 4'he, 4'hf};
    foreach (m[i])
    begin
      apb(`SSP_ADDR_CTRL, 1'b1, {4'h3, m[i]});
      apb(`SSP_ADDR_CTRL, 1'b0, 8'h00);
      chk(rd[7:0], {4'h3, m[i]}, "mode readback");
      chk({6'h0, sckOe, sckOut & sckOe}, m[i] < 4'h4 ? 8'h03 : 8'h00, "clock pin");
      apb(`SSP_ADDR_CTRL, 1'b1, 8'h00);
      chk({4'h0, sdiOut, sckOe, sdoOe, sdiOe}, 8'h00, "pins released");
    end
  endtask

  // Master word with a colliding write; both sample phases at two clock sources.
  // The timer rate needs late sampling: the pin delay outruns a two-cycle half period.
  task automatic t_master(input logic sample_phase, input logic [3:0] md);
    apb(`SSP_ADDR_STAT, 1'b1, {sample_phase, 7'h00});
    ssp_spi_partner_inst.arm(8'h3c);
    apb(`SSP_ADDR_CTRL, 1'b1, {4'h2, md});
    apb(`SSP_ADDR_DATA, 1'b1, 8'ha5);
    apb(`SSP_ADDR_DATA, 1'b1, 8'h5a);
    waitBf();
    apb(`SSP_ADDR_DATA, 1'b0, 8'h00);
    chk(rd[7:0], 8'h3c, "master receive");
    chk(rxByte, 8'ha5, "master transmit");
    apb(`SSP_ADDR_CTRL, 1'b0, 8'h00);
    chk(rd[7:0], {4'ha, md}, "collision flag");
    apb(`SSP_ADDR_STAT, 1'b0, 8'h00);
    chk(rd[7:0], {sample_phase, 7'h00}, "buffer emptied");
    apb(`SSP_ADDR_CTRL, 1'b1, 8'h00);
    apb(`SSP_ADDR_CTRL, 1'b0, 8'h00);
    chk(rd[7:0], 8'h00, "flag cleared");
    apb(`SSP_ADDR_STAT, 1'b1, 8'h00);
  endtask

  task automatic sx(input logic [7:0] b);
    ssp_spi_partner_inst.xfer(b);
    repeat (4) @(posedge clock);
  endtask

  // Slave words with select; the third arrives with the buffer full.
  task automatic t_slave;
    apb(`SSP_ADDR_CTRL, 1'b1, 8'h24);
    apb(`SSP_ADDR_DATA, 1'b1, 8'h96);
    sx(8'h69);
    waitBf();
    chk(rxByte, 8'h96, "slave transmit");
    apb(`SSP_ADDR_DATA, 1'b0, 8'h00);
    chk(rd[7:0], 8'h69, "slave receive");
    sx(8'h11);
    sx(8'h22);
    apb(`SSP_ADDR_CTRL, 1'b0, 8'h00);
    chk(rd[7:0], 8'h64, "overflow flag");
    apb(`SSP_ADDR_DATA, 1'b0, 8'h00);
    chk(rd[7:0], 8'h11, "older byte kept");
  endtask

  // I2C slave: an address byte that matches, then a stop from the far side.
  task automatic t_i2c;
    apb(`SSP_ADDR_CTRL, 1'b1, 8'h00);
    apb(`SSP_ADDR_SADR, 1'b1, 8'h42);
    apb(`SSP_ADDR_CTRL, 1'b1, 8'h26);
    ssp_spi_partner_inst.i2cAddr(8'h42);
    repeat (4) @(posedge clock);
    apb(`SSP_ADDR_STAT, 1'b0, 8'h00);
    chk(rd[7:0], 8'h09, "start and address");
    apb(`SSP_ADDR_DATA, 1'b0, 8'h00);
    chk(rd[7:0], 8'h42, "address stored");
    ssp_spi_partner_inst.i2cStop();
    repeat (4) @(posedge clock);
    apb(`SSP_ADDR_STAT, 1'b0, 8'h00);
    chk(rd[7:0], 8'h10, "stop seen");
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_modes();
    t_master(1'b0, `SSP_MODE_DIV16);
    t_master(1'b1, `SSP_MODE_TMR2);
    t_slave();
    t_i2c();
    finish_test();
  end
endmodule
